// [rtl/i2crp_cfg.svh]
// Purpose: Constants for the two-wire register port
// Assumes: Included by the port design file and by the bench
// Notes: Offsets, address fields and sizes live here
`ifndef I2CRP_CFG_SVH
`define I2CRP_CFG_SVH

// ****************************************************************
// Slave address
// ****************************************************************
`define I2CRP_ADDR_HI 5'h0a
`define I2CRP_ADDR_HI_W 5

// ****************************************************************
// Register space
// ****************************************************************
`define I2CRP_REG_AW 7
`define I2CRP_BUF_ADDR 7'h05
`define I2CRP_PTR_RST 7'h00
`define I2CRP_NUM_REGS 128

// ****************************************************************
// Link limits
// ****************************************************************
`define I2CRP_FSCL_MAX_KHZ 5000
`define I2CRP_BYTE_W 8

`endif

// [rtl/i2crp_pkg.sv]
// Purpose: Types for the two-wire register port
// Assumes: Nothing beyond the tool's SystemVerilog support
// Notes: Link state machine encoding is left to the tool
package i2crp_pkg;
  typedef enum logic [2:0] {
    I2CRP_IDLE,
    I2CRP_ADDR,
    I2CRP_ADDR_ACK,
    I2CRP_RX,
    I2CRP_RX_ACK,
    I2CRP_TX,
    I2CRP_TX_ACK,
    I2CRP_IGNORE
  } i2crp_state_t;
endpackage

// [rtl/i2crp_stream_if.sv]
// Purpose: Valid/ready byte stream between the block's modules
// Assumes: Source and sink share one clock
// Notes: A word moves when valid and ready are both high
`timescale 1ns/100ps
interface i2crp_stream_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [rtl/i2crp_sync.sv]
// Purpose: Two flip-flop level synchroniser
// Assumes: Input is a slow level from another domain
// Notes: First stage is read only by the second stage
`timescale 1ns/100ps
module i2crp_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic meta;

  // ****************************************************************
  // Two stages
  // ****************************************************************
  // Capture then settle
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// [rtl/i2crp_buf2.sv]
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: One clock for both sides
// Notes: Full and empty are exact; stalls reach the source
`timescale 1ns/100ps
module i2crp_buf2 (
  input wire logic clk,
  input wire logic rst,
  i2crp_stream_if.snk in_s,
  i2crp_stream_if.src out_s
);
  logic [7:0] mem [0:1];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  wire full = (count == 2'h2);
  wire empty = (count == 2'h0);
  wire do_wr = in_s.valid && !full;
  wire do_rd = out_s.ready && !empty;

  // ****************************************************************
  // Handshakes
  // ****************************************************************
  // Ready while room remains, valid while data is held
  assign in_s.ready = !full;
  assign out_s.valid = !empty;
  assign out_s.data = mem[rd_ptr];

  // Storage write
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_s.data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      wr_ptr <= wr_ptr ^ do_wr;
      rd_ptr <= rd_ptr ^ do_rd;
      count <= count + {1'b0, do_wr} - {1'b0, do_rd};
    end
  end
endmodule

// [rtl/i2crp_port.sv]
// Purpose: Slave side of the light two-wire register port
// Assumes: SCL comes from the master and may stop between frames
// Notes: Register store and buffer sit on sys_clk
`timescale 1ns/100ps
`include "i2crp_cfg.svh"
module i2crp_port
  import i2crp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic scl_clk,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic addr_from_pin,
  input wire logic [1:0] addr_pin,
  input wire logic [1:0] addr_nvm,
  output logic [7:0] buf_data,
  output logic buf_valid,
  input wire logic buf_ready,
  input wire logic [7:0] buf_rd_data,
  input wire logic buf_rd_valid,
  output logic buf_rd_ready,
  output logic link_busy
);
  // ****************************************************************
  // Slave address
  // ****************************************************************
  // One master only: host or secure access module
  // Low bits from pin force the upper one to zero
  wire [1:0] low_bits = addr_from_pin ? {1'b0, addr_pin[0]} : addr_nvm;
  wire [6:0] my_addr = {`I2CRP_ADDR_HI, low_bits};

  // ****************************************************************
  // Start and stop detection in the link domain
  // ****************************************************************
  // SDA falls with SCL high: start; rises: stop. Flags are toggles
  logic start_tgl;
  logic stop_tgl;
  logic start_seen;
  logic start_ack;
  always_ff @(negedge sda_i or posedge sys_rst) begin
    if (sys_rst) begin
      start_tgl <= 1'b0;
    end else if (scl_clk) begin
      start_tgl <= ~start_tgl;
    end
  end
  always_ff @(posedge sda_i or posedge sys_rst) begin
    if (sys_rst) begin
      stop_tgl <= 1'b0;
    end else if (scl_clk) begin
      stop_tgl <= ~stop_tgl;
    end
  end
  assign start_seen = start_tgl != start_ack;

  // ****************************************************************
  // Link state machine on SCL rising edge
  // ****************************************************************
  i2crp_state_t state;
  logic [7:0] shreg;
  logic [2:0] bitcnt;
  logic rw;
  logic got_ptr;
  logic [6:0] ptr;
  logic [7:0] rx_byte;
  logic rx_tgl;
  logic rx_is_ptr;
  logic tx_req_tgl;
  logic [6:0] rx_addr;
  logic stop_ack;
  wire stop_seen = stop_tgl != stop_ack;
  wire [6:0] ptr_inc = (ptr == `I2CRP_BUF_ADDR) ? ptr : ptr + 7'h01;

  // Bits sampled on the rising SCL edge; SCL up to 5 MHz
  always_ff @(posedge scl_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= I2CRP_IDLE;
      shreg <= 8'h00;
      bitcnt <= 3'h0;
      rw <= 1'b0;
      got_ptr <= 1'b0;
      ptr <= `I2CRP_PTR_RST;
      rx_byte <= 8'h00;
      rx_tgl <= 1'b0;
      rx_is_ptr <= 1'b0;
      rx_addr <= `I2CRP_PTR_RST;
      tx_req_tgl <= 1'b0;
      start_ack <= 1'b0;
      stop_ack <= 1'b0;
    end else begin
      stop_ack <= stop_tgl;
      if (start_seen) begin
        start_ack <= start_tgl;
        state <= I2CRP_ADDR;
        shreg <= {7'h00, sda_i};
        bitcnt <= 3'h1;
        got_ptr <= 1'b0;
      end else if (stop_seen) begin
        state <= I2CRP_IDLE;
      end else begin
        case (state)
          I2CRP_ADDR: begin
            shreg <= {shreg[6:0], sda_i};
            bitcnt <= bitcnt + 3'h1;
            if (bitcnt == 3'h7) begin
              rw <= sda_i;
              // A foreign address is ignored, no arbitration
              state <= (shreg[6:0] == my_addr) ? I2CRP_ADDR_ACK
                                               : I2CRP_IGNORE;
            end
          end
          I2CRP_ADDR_ACK: begin
            bitcnt <= 3'h0;
            if (rw) begin
              state <= I2CRP_TX;
              tx_req_tgl <= ~tx_req_tgl;
            end else begin
              state <= I2CRP_RX;
            end
          end
          I2CRP_RX: begin
            shreg <= {shreg[6:0], sda_i};
            bitcnt <= bitcnt + 3'h1;
            if (bitcnt == 3'h7) begin
              state <= I2CRP_RX_ACK;
              rx_byte <= {shreg[6:0], sda_i};
              rx_is_ptr <= !got_ptr;
              if (!got_ptr) begin
                ptr <= shreg[6:0] == 7'h00 ? sda_i ? 7'h01 : 7'h00
                       : {shreg[5:0], sda_i};
                got_ptr <= 1'b1;
              end else begin
                rx_addr <= ptr;
                ptr <= ptr_inc;
              end
              rx_tgl <= ~rx_tgl;
            end
          end
          I2CRP_RX_ACK: begin
            bitcnt <= 3'h0;
            state <= I2CRP_RX;
          end
          I2CRP_TX: begin
            bitcnt <= bitcnt + 3'h1;
            if (bitcnt == 3'h7) begin
              state <= I2CRP_TX_ACK;
            end
          end
          I2CRP_TX_ACK: begin
            bitcnt <= 3'h0;
            if (sda_i) begin
              state <= I2CRP_IGNORE;
            end else begin
              state <= I2CRP_TX;
              ptr <= ptr_inc;
              tx_req_tgl <= ~tx_req_tgl;
            end
          end
          default: begin
            state <= state;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Drive SDA on the falling SCL edge only
  // ****************************************************************
  // Enable changes while SCL is low; released while idle
  logic [7:0] tx_shift;
  logic [7:0] tx_hold;
  always_ff @(negedge scl_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sda_oe <= 1'b0;
      sda_o <= 1'b1;
      tx_shift <= 8'h00;
    end else begin
      case (state)
        I2CRP_ADDR_ACK, I2CRP_RX_ACK: begin
          sda_oe <= 1'b1;
          sda_o <= 1'b0;
          tx_shift <= tx_hold;
        end
        I2CRP_TX: begin
          sda_oe <= 1'b1;
          sda_o <= (bitcnt == 3'h0) ? tx_hold[7] : tx_shift[7];
          tx_shift <= (bitcnt == 3'h0) ? {tx_hold[6:0], 1'b0}
                                       : {tx_shift[6:0], 1'b0};
        end
        default: begin
          sda_oe <= 1'b0;
          sda_o <= sda_o;
        end
      endcase
    end
  end
  // SCL is never driven here: no stretching

  // ****************************************************************
  // Crossing into sys_clk
  // ****************************************************************
  // Byte and pointer are stable while the toggle settles
  logic rx_tgl_s;
  logic rx_tgl_d;
  logic tx_req_s;
  logic tx_req_d;
  logic busy_s;
  // A stop seen with SCL high ends the frame before any further SCL rise
  wire in_frame = (state != I2CRP_IDLE) && !stop_seen;
  i2crp_sync u_rx_sync (.clk(sys_clk), .rst(sys_rst), .din(rx_tgl),
                        .dout(rx_tgl_s));
  i2crp_sync u_tx_sync (.clk(sys_clk), .rst(sys_rst), .din(tx_req_tgl),
                        .dout(tx_req_s));
  i2crp_sync u_busy_sync (.clk(sys_clk), .rst(sys_rst), .din(in_frame),
                          .dout(busy_s));
  wire rx_evt = rx_tgl_s != rx_tgl_d;
  wire tx_evt = tx_req_s != tx_req_d;

  // ****************************************************************
  // Register store and buffer paths on sys_clk
  // ****************************************************************
  logic [7:0] regs [0:`I2CRP_NUM_REGS-1];
  i2crp_stream_if wr_in ();
  i2crp_stream_if wr_out ();
  // Target address is latched with the byte, so a step onto the buffer
  // address never redirects the byte that came before it
  wire wr_buf = rx_evt && !rx_is_ptr && rx_addr == `I2CRP_BUF_ADDR;
  wire wr_reg = rx_evt && !rx_is_ptr && rx_addr != `I2CRP_BUF_ADDR;
  assign wr_in.valid = wr_buf;
  assign wr_in.data = rx_byte;
  assign buf_valid = wr_out.valid;
  assign buf_data = wr_out.data;
  assign wr_out.ready = buf_ready;
  i2crp_buf2 u_wr_buf (.clk(sys_clk), .rst(sys_rst), .in_s(wr_in),
                       .out_s(wr_out));
  assign buf_rd_ready = tx_evt && buf_rd_valid && ptr == `I2CRP_BUF_ADDR;
  assign link_busy = busy_s;

  // Edge detect and register writes
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rx_tgl_d <= 1'b0;
      tx_req_d <= 1'b0;
      tx_hold <= 8'h00;
    end else begin
      rx_tgl_d <= rx_tgl_s;
      tx_req_d <= tx_req_s;
      if (wr_reg) begin
        regs[rx_addr] <= rx_byte;
      end
      if (tx_evt) begin
        tx_hold <= (ptr == `I2CRP_BUF_ADDR) ?
                   (buf_rd_valid ? buf_rd_data : 8'h00) : regs[ptr];
      end
    end
  end
endmodule

// [testbench/i2crp_chk.sv]
// Purpose: Port checker for the two-wire register port
// Assumes: Bound to the port's top module
// Notes: The link clock is watched as a level on sys_clk
`timescale 1ns/100ps
module i2crp_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic scl_clk,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic [7:0] buf_data,
  input wire logic buf_valid,
  input wire logic buf_ready,
  input wire logic buf_rd_valid,
  input wire logic buf_rd_ready,
  input wire logic link_busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ****************
  // Link rules
  // ****************
  AST_SCL_HI_OE: assert property (
    scl_clk && $past(scl_clk) |-> $stable(sda_oe)) else $error("oe moved");
  AST_SCL_HI_DO: assert property (
    scl_clk && $past(scl_clk) && sda_oe |-> $stable(sda_o))
    else $error("data moved with clock high");
  AST_OE_ON: assert property (
    $rose(sda_oe) |-> !scl_clk) else $error("drive began with clock high");
  AST_OE_OFF: assert property (
    $fell(sda_oe) |-> !scl_clk) else $error("release with clock high");
  AST_OE_IDLE: assert property (
    !link_busy [*8] |-> !sda_oe) else $error("drive outside frame");
  // ****************
  // Stream rules
  // ****************
  AST_BUF_HOLD: assert property (
    buf_valid && !buf_ready |=> buf_valid && $stable(buf_data))
    else $error("stalled byte lost");
  AST_RD_PULSE: assert property (
    buf_rd_ready |=> !buf_rd_ready) else $error("take not a pulse");
  AST_RD_VALID: assert property (
    buf_rd_ready |-> link_busy) else $error("take outside frame");
  cover property (buf_valid && !buf_ready);
  cover property ($rose(sda_oe));
  cover property (buf_rd_ready);
endmodule

bind i2crp_port i2crp_chk chk_i (.sys_clk, .sys_rst, .scl_clk, .sda_o,
  .sda_oe, .buf_data, .buf_valid, .buf_ready, .buf_rd_valid,
  .buf_rd_ready, .link_busy);

// [testbench/i2crp_master.sv]
// Purpose: Master model for the light two-wire link
// Assumes: Device samples SDA on the SCL rise
// Notes: Half period hp is set by the bench
`timescale 1ns/100ps
module i2crp_master (
  output logic scl,
  output logic m_oe,
  output logic m_val,
  input wire logic sda
);
  int hp = 100;
  // Idle: clock high, data driven high
  initial begin
    scl = 1'b1;
    m_oe = 1'b1;
    m_val = 1'b1;
  end
  // One bit out, driven only while the clock is low
  task automatic bit_out(input logic b);
    #(hp / 4) m_oe = 1'b1;
    m_val = b;
    #(hp / 4) m_oe = 1'b0;
    #(hp / 2) scl = 1'b1;
    #hp scl = 1'b0;
  endtask
  // One bit in, line left to the device
  task automatic bit_in(output logic b);
    m_oe = 1'b0;
    #hp scl = 1'b1;
    #(hp / 2) b = sda;
    #(hp / 2) scl = 1'b0;
  endtask
  task automatic start();
    #(hp / 4) m_oe = 1'b1;
    m_val = 1'b1;
    #(hp / 2) scl = 1'b1;
    #hp m_val = 1'b0;
    #hp scl = 1'b0;
  endtask
  task automatic stop();
    #(hp / 4) m_oe = 1'b1;
    m_val = 1'b0;
    #(hp / 2) scl = 1'b1;
    #hp m_val = 1'b1;
    #(hp * 2);
  endtask
  // Byte out MSB first, ack returned
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(b);
    ack = !b;
  endtask
  // Byte in, last one not acknowledged
  task automatic byte_in(output logic [7:0] d, input logic nack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_in(b);
      d[i] = b;
    end
    bit_out(nack);
  endtask
endmodule

// [testbench/tb.sv]
// Purpose: Self-checking bench for the two-wire register port
// Assumes: Master model drives the link clock
// Notes: Wire level resolves both drivers and the keeper
`timescale 1ns/100ps
`include "i2crp_cfg.svh"
module tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b0;
  logic scl, m_oe, m_val, sda_o, sda_oe, a, buf_valid;
  logic kept = 1'b1;
  logic oe_seen = 1'b0;
  logic buf_rd_ready, link_busy, addr_from_pin = 1'b0;
  logic [1:0] addr_pin = 2'h3;
  logic [1:0] addr_nvm = 2'h1;
  logic [7:0] buf_data, d, buf_rd_data = 8'h40;
  logic buf_ready = 1'b0;
  logic buf_rd_valid = 1'b1;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  localparam logic [6:0] dev = {`I2CRP_ADDR_HI, 2'h1};
  always #10 sys_clk = ~sys_clk;
  // Keeper holds the last driven level
  always @* if (sda_oe === 1'b1) kept = sda_o;
    else if (m_oe) kept = m_val;
  // Device drive seen in the current frame
  always @(posedge sda_oe) oe_seen = 1'b1;
  // Read source steps on each take
  always @(posedge sys_clk) if (buf_rd_ready) buf_rd_data <= buf_rd_data + 8'h01;
  i2crp_port dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .scl_clk(scl),
    .sda_i(kept), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_from_pin(addr_from_pin), .addr_pin(addr_pin),
    .addr_nvm(addr_nvm), .buf_data(buf_data), .buf_valid(buf_valid),
    .buf_ready(buf_ready), .buf_rd_data(buf_rd_data),
    .buf_rd_valid(buf_rd_valid), .buf_rd_ready(buf_rd_ready),
    .link_busy(link_busy));
  i2crp_master m (.scl(scl), .m_oe(m_oe), .m_val(m_val), .sda(kept));
  task automatic stop_test();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk_byte(string n, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", n, e, g);
      fails++;
    end
  endtask
  task automatic chk_bit(string n, logic e, logic g);
    check_count++;
    if (g !== e) begin
      $display("[ERR] %s exp %b got %b", n, e, g);
      fails++;
    end
  endtask
  task automatic wb(logic [7:0] v, logic e);
    m.byte_out(v, a);
    chk_bit("ack", e, a);
  endtask
  // Address match from addr_nvm bits and from pins
  task automatic t_addr();
    for (int i = 0; i < 4; i++) begin
      @(negedge sys_clk) addr_from_pin = i[1];
      addr_nvm = 2'h2;
      oe_seen = 1'b0;
      m.start();
      // Keeper holds the last level, so a missing ack shows as no drive
      m.byte_out({5'h0a, i[0] ? 2'h3 : (i[1] ? 2'h1 : 2'h2), 1'b0}, a);
      chk_bit("addr_ack", !i[0], oe_seen);
      m.stop();
    end
    @(negedge sys_clk) addr_from_pin = 1'b0;
    addr_nvm = 2'h1;
  endtask
  // Burst write, pointer set, burst read back
  task automatic t_reg();
    m.start();
    wb({dev, 1'b0}, 1'b1);
    wb(8'h10, 1'b1);
    wb(8'hd4, 1'b1);
    wb(8'he5, 1'b1);
    m.stop();
    m.start();
    wb({dev, 1'b0}, 1'b1);
    wb(8'h10, 1'b1);
    m.stop();
    m.start();
    wb({dev, 1'b1}, 1'b1);
    m.byte_in(d, 1'b0);
    chk_byte("rd0", 8'hd4, d);
    m.byte_in(d, 1'b1);
    chk_byte("rd1", 8'he5, d);
    #20 chk_bit("release", 1'b0, sda_oe);
    m.stop();
  endtask
  // Buffer writes under stall, then drained
  task automatic t_bufw();
    m.start();
    wb({dev, 1'b0}, 1'b1);
    wb({1'b0, `I2CRP_BUF_ADDR}, 1'b1);
    wb(8'ha1, 1'b1);
    wb(8'hb2, 1'b1);
    m.stop();
    for (int j = 0; j < 2; j++) begin
      @(negedge sys_clk) chk_bit("bvalid", 1'b1, buf_valid);
      chk_byte("bdata", j ? 8'hb2 : 8'ha1, buf_data);
      buf_ready = 1'b1;
      @(negedge sys_clk) buf_ready = 1'b0;
    end
    chk_bit("bempty", 1'b0, buf_valid);
  endtask
  // Buffer reads keep the pointer fixed
  task automatic t_bufr();
    logic [7:0] base;
    base = buf_rd_data;
    m.start();
    wb({dev, 1'b0}, 1'b1);
    wb({1'b0, `I2CRP_BUF_ADDR}, 1'b1);
    m.stop();
    m.start();
    wb({dev, 1'b1}, 1'b1);
    for (int j = 0; j < 3; j++) begin
      m.byte_in(d, j == 2);
      chk_byte("bufrd", base + 8'(j), d);
    end
    m.stop();
  endtask
  // Cycle ceiling
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      stop_test();
    end
  end
  // Main sequence
  initial begin
    #1 sys_rst = 1'b1;
    repeat (12) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    t_addr();
    t_reg();
    t_bufw();
    m.hp = 400;
    t_bufr();
    stop_test();
  end
endmodule
